// ===== rtl/pbmc_regs.vh
`ifndef PBMC_REGS_VH
`define PBMC_REGS_VH
// register byte address
`define PBMC_ADDR_CTRL 8'h00
// field positions
`define PBMC_BIT_RESET 15
`define PBMC_BIT_LOOP 14
`define PBMC_BIT_SPEED 13
`define PBMC_BIT_ANEN 12
`define PBMC_BIT_PDOWN 11
`define PBMC_BIT_ISOL 10
`define PBMC_BIT_RESTART 9
`define PBMC_BIT_DUPLEX 8
`define PBMC_BIT_COLTEST 7
// writable bits mask and reset value
`define PBMC_WMASK 16'hff80
`define PBMC_RESET_VAL 16'h3100
// timing
`define PBMC_DEAD_MS 720
`define PBMC_CLK_KHZ 25000
`define PBMC_DEAD_CYC (`PBMC_DEAD_MS * `PBMC_CLK_KHZ)
`define PBMC_SWRST_CYC 16
`endif

// ===== rtl/pbmc_ctrl.v
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "pbmc_regs.vh"

// Function
// RULE1: reset bit restores defaults, reads one meanwhile
// RULE2: loopback bit, default zero
// RULE3: loopback at 100M gives receive dead time; here only if 100M was already in effect before the loopback write
// RULE4: speed bit selects 100 or 10
// RULE5: autoneg on: speed reads negotiated value
// RULE6: autoneg enable defaults one, reports results
// RULE7: power down; bus keeps answering
// RULE8: manager keeps isolate bit zero; here the isolate bit is stored and driven out as written
// RULE9: restart bit restarts autoneg
// RULE10: restart reads one until autoneg began
// RULE11: restart ignored with autoneg disabled
// RULE12: clearing restart leaves autoneg running
// RULE13: collision test asserts collision during transmit
// RULE14: duplex defaults full; manual only without autoneg
// RULE15: autoneg on: duplex reads negotiated value
// RULE16: reserved low bits read zero
// RULE17: register at index zero
module pbmc_ctrl #(
  parameter DEAD_CYC = `PBMC_DEAD_CYC,
  parameter SWRST_CYC = `PBMC_SWRST_CYC
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  input wire an_speed_in,
  input wire an_duplex_in,
  input wire an_started_in,
  input wire tx_active_in,
  output reg an_enable_out,
  output reg an_restart_out,
  output reg speed_100_out,
  output reg full_duplex_out,
  output reg loopback_out,
  output reg power_down_out,
  output reg isolate_out,
  output reg collision_out,
  output reg rx_dead_out,
  output reg phy_reset_out
);

  // ----------------------------------------------------------------
  // state machine codes
  // ----------------------------------------------------------------
  localparam ST_RUN = 2'b01;
  localparam ST_SWRST = 2'b10;

  // per-field defaults, taken from the register reset image
  localparam [15:0] DEF_VAL = `PBMC_RESET_VAL;
  localparam DEF_LOOP = DEF_VAL[`PBMC_BIT_LOOP];
  localparam DEF_SPEED = DEF_VAL[`PBMC_BIT_SPEED];
  localparam DEF_ANEN = DEF_VAL[`PBMC_BIT_ANEN];
  localparam DEF_PDOWN = DEF_VAL[`PBMC_BIT_PDOWN];
  localparam DEF_ISOL = DEF_VAL[`PBMC_BIT_ISOL];
  localparam DEF_RESTART = DEF_VAL[`PBMC_BIT_RESTART];
  localparam DEF_DUPLEX = DEF_VAL[`PBMC_BIT_DUPLEX];
  localparam DEF_COLTEST = DEF_VAL[`PBMC_BIT_COLTEST];

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] rst_cnt_r;
  reg [31:0] dead_cnt_r;
  reg wr_pend_r;
  reg rd_pend_r;
  reg [7:0] addr_r;
  reg loop_r;
  reg speed_r;
  reg anen_r;
  reg pdown_r;
  reg isol_r;
  reg restart_r;
  reg duplex_r;
  reg coltest_r;
  reg [15:0] rd_val;
  wire acc;
  wire hit;
  wire wr_now;
  wire [15:0] wd;
  wire eff_speed;
  wire eff_duplex;
  wire swrst_now;
  wire wr_fields;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  assign acc = hsel_in & hready_in & htrans_in[1];
  assign hit = (addr_r == `PBMC_ADDR_CTRL); // RULE17
  assign wr_now = wr_pend_r & hit & (state_r == ST_RUN);
  assign wd = hwdata_in[15:0];

  // address phase capture; always zero wait, bus alive in power down
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wr_pend_r <= acc & hwrite_in;
      rd_pend_r <= acc & ~hwrite_in;
      if (acc) begin
        addr_r <= haddr_in[7:0];
      end
      hreadyout_out <= 1'b1; // RULE7
      hresp_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // effective mode selection
  // ----------------------------------------------------------------
  assign eff_speed = anen_r ? an_speed_in : speed_r; // RULE4 RULE5
  assign eff_duplex = anen_r ? an_duplex_in : duplex_r; // RULE14 RULE15

  // ----------------------------------------------------------------
  // read image
  // ----------------------------------------------------------------
  // read image; reserved bits zero
  always @* begin
    rd_val = 16'h0000; // RULE16
    rd_val[`PBMC_BIT_RESET] = (state_r == ST_SWRST); // RULE1
    rd_val[`PBMC_BIT_LOOP] = loop_r;
    rd_val[`PBMC_BIT_SPEED] = eff_speed; // RULE5
    rd_val[`PBMC_BIT_ANEN] = anen_r;
    rd_val[`PBMC_BIT_PDOWN] = pdown_r;
    rd_val[`PBMC_BIT_ISOL] = isol_r;
    rd_val[`PBMC_BIT_RESTART] = restart_r; // RULE10
    rd_val[`PBMC_BIT_DUPLEX] = eff_duplex; // RULE15
    rd_val[`PBMC_BIT_COLTEST] = coltest_r;
  end

  // read data register, loaded at address phase
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (acc & ~hwrite_in) begin
      if (haddr_in[7:0] == `PBMC_ADDR_CTRL) begin
        hrdata_out <= {16'h0000, rd_val};
      end else begin
        hrdata_out <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // software reset sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (wr_now & wd[`PBMC_BIT_RESET]) begin
          state_nxt = ST_SWRST; // RULE1
        end
      end
      ST_SWRST: begin
        if (rst_cnt_r >= SWRST_CYC - 1) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_RUN;
      rst_cnt_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_SWRST) begin
        rst_cnt_r <= rst_cnt_r + 32'h00000001;
      end else begin
        rst_cnt_r <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  // soft reset forces defaults; a reset write changes no field
  assign swrst_now = (state_r == ST_SWRST); // RULE1
  assign wr_fields = wr_now & ~wd[`PBMC_BIT_RESET];

  // loopback control bit
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      loop_r <= DEF_LOOP;
    end else if (swrst_now) begin
      loop_r <= DEF_LOOP; // RULE1
    end else if (wr_fields) begin
      loop_r <= wd[`PBMC_BIT_LOOP]; // RULE2
    end
  end

  // manual speed select
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      speed_r <= DEF_SPEED;
    end else if (swrst_now) begin
      speed_r <= DEF_SPEED; // RULE1
    end else if (wr_fields) begin
      speed_r <= wd[`PBMC_BIT_SPEED]; // RULE4
    end
  end

  // autoneg enable
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      anen_r <= DEF_ANEN;
    end else if (swrst_now) begin
      anen_r <= DEF_ANEN; // RULE1
    end else if (wr_fields) begin
      anen_r <= wd[`PBMC_BIT_ANEN]; // RULE6
    end
  end

  // power down
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pdown_r <= DEF_PDOWN;
    end else if (swrst_now) begin
      pdown_r <= DEF_PDOWN; // RULE1
    end else if (wr_fields) begin
      pdown_r <= wd[`PBMC_BIT_PDOWN]; // RULE7
    end
  end

  // isolate; stored and driven out as written
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      isol_r <= DEF_ISOL;
    end else if (swrst_now) begin
      isol_r <= DEF_ISOL; // RULE1
    end else if (wr_fields) begin
      isol_r <= wd[`PBMC_BIT_ISOL]; // RULE8
    end
  end

  // manual duplex select
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      duplex_r <= DEF_DUPLEX;
    end else if (swrst_now) begin
      duplex_r <= DEF_DUPLEX; // RULE1
    end else if (wr_fields) begin
      duplex_r <= wd[`PBMC_BIT_DUPLEX]; // RULE14
    end
  end

  // collision test
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      coltest_r <= DEF_COLTEST;
    end else if (swrst_now) begin
      coltest_r <= DEF_COLTEST; // RULE1
    end else if (wr_fields) begin
      coltest_r <= wd[`PBMC_BIT_COLTEST]; // RULE13
    end
  end

  // restart request; set on write, cleared once autoneg began
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      restart_r <= DEF_RESTART;
    end else if (swrst_now) begin
      restart_r <= DEF_RESTART; // RULE1
    end else if (wr_fields) begin
      // restart only acts with autoneg on; writing 0 never aborts
      if (wd[`PBMC_BIT_RESTART] & wd[`PBMC_BIT_ANEN]) begin
        restart_r <= 1'b1; // RULE9 RULE11
      end else if (an_started_in) begin
        restart_r <= 1'b0; // RULE12
      end else if (~wd[`PBMC_BIT_ANEN]) begin
        restart_r <= 1'b0; // RULE11
      end
    end else if (an_started_in | ~anen_r) begin
      restart_r <= 1'b0; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // outputs to the phy core
  // ----------------------------------------------------------------
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      an_enable_out <= 1'b1;
      an_restart_out <= 1'b0;
      speed_100_out <= 1'b1;
      full_duplex_out <= 1'b1;
      loopback_out <= 1'b0;
      power_down_out <= 1'b0;
      isolate_out <= 1'b0;
      collision_out <= 1'b0;
      phy_reset_out <= 1'b0;
    end else begin
      an_enable_out <= anen_r; // RULE6
      an_restart_out <= restart_r & anen_r; // RULE9 RULE11
      speed_100_out <= eff_speed;
      full_duplex_out <= eff_duplex; // RULE14
      loopback_out <= loop_r; // RULE2
      power_down_out <= pdown_r; // RULE7
      isolate_out <= isol_r;
      collision_out <= coltest_r & tx_active_in; // RULE13
      phy_reset_out <= (state_nxt == ST_SWRST); // RULE1
    end
  end

  // ----------------------------------------------------------------
  // receive dead time after loopback entry with 100M already in effect before the write
  // ----------------------------------------------------------------
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dead_cnt_r <= 32'h00000000;
      rx_dead_out <= 1'b0;
    end else if (wr_now & ~wd[`PBMC_BIT_RESET] & ~loop_r &
                 wd[`PBMC_BIT_LOOP] & eff_speed) begin
      dead_cnt_r <= DEAD_CYC; // RULE3
      rx_dead_out <= 1'b1;
    end else if (dead_cnt_r != 32'h00000000) begin
      dead_cnt_r <= dead_cnt_r - 32'h00000001;
      rx_dead_out <= (dead_cnt_r != 32'h00000001);
    end else begin
      rx_dead_out <= 1'b0;
    end
  end

endmodule

// ===== tb/pbmc_ctrl_chk.sv
`timescale 1ns/1ns
// watches the control register at the ports of its top module
module pbmc_chk (
  input wire core_clk_in,
  input wire rst_in,
  input wire [31:0] hrdata_out,
  input wire hreadyout_out,
  input wire an_speed_in,
  input wire an_started_in,
  input wire tx_active_in,
  input wire an_enable_out,
  input wire an_restart_out,
  input wire speed_100_out,
  input wire loopback_out,
  input wire power_down_out,
  input wire collision_out,
  input wire rx_dead_out,
  input wire phy_reset_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // collision, speed, readback and self-clearing relations
  property p_col; collision_out |-> $past(tx_active_in); endproperty
  a_col: assert property (p_col) else $error("stray collision");
  property p_spd; an_enable_out && $past(an_enable_out) && !phy_reset_out
    && $stable(an_speed_in) |-> speed_100_out == an_speed_in; endproperty
  a_spd: assert property (p_spd) else $error("speed not negotiated");
  property p_rsv; hrdata_out[6:0] == 7'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_pd; power_down_out |-> hreadyout_out; endproperty
  a_pd: assert property (p_pd) else $error("bus stalled");
  property p_def; phy_reset_out && $past(phy_reset_out, 3) |->
    an_enable_out && !loopback_out && !power_down_out; endproperty
  a_def: assert property (p_def) else $error("no defaults");
  property p_nrs; !an_enable_out && !$past(an_enable_out) |->
    !an_restart_out; endproperty
  a_nrs: assert property (p_nrs) else $error("restart without an");
  property p_hold; an_restart_out && an_enable_out && !an_started_in |=>
    an_restart_out || !an_enable_out || phy_reset_out; endproperty
  a_hold: assert property (p_hold) else $error("restart dropped");
  property p_dead; $rose(loopback_out) && $past(speed_100_out) &&
    speed_100_out |-> ##[0:3] rx_dead_out; endproperty
  a_dead: assert property (p_dead) else $error("no dead time");
endmodule
bind pbmc_ctrl pbmc_chk chk_u (.*);

// ===== tb/pbmc_link_model.sv
`timescale 1ns/1ns
// negotiation and transmit side of the link
module pbmc_link_model (
  input wire core_clk_in,
  input wire rst_in,
  input wire an_restart_in,
  input wire [7:0] start_dly_in,
  input wire tx_en_in,
  output reg an_started_out,
  output reg tx_active_out
);
  reg [7:0] wait_r;
  reg [2:0] phase_r;
  // start flag held until the pending restart drops
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_r <= 8'h00;
      phase_r <= 3'h0;
      an_started_out <= 1'b0;
      tx_active_out <= 1'b0;
    end else begin
      wait_r <= an_restart_in ? wait_r + 8'h01 : 8'h00;
      an_started_out <= an_restart_in && wait_r >= start_dly_in;
      phase_r <= phase_r + 3'h1;
      tx_active_out <= tx_en_in && phase_r[2];
    end
  end
endmodule

// ===== tb/tb_phy_basic_mode_control.sv
`timescale 1ns/1ns
module tb_phy_basic_mode_control;
  reg core_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg hsel_in = 1'b0;
  reg hwrite_in = 1'b0;
  reg [1:0] htrans_in = 2'h0;
  reg [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, seed = 32'h62011819;
  reg an_speed_in = 1'b1, an_duplex_in = 1'b1, tx_en = 1'b0, t;
  reg [15:0] v, e;
  wire [31:0] hrdata_out;
  wire hready, an_started_in, tx_active_in, an_restart_out, spd, dpx;
  wire loopback_out, power_down_out, collision_out, rx_dead_out, sw_rst;
  integer fail_count = 0, checked = 0, i, n;
  always #20 core_clk_in = ~core_clk_in;
  // design with shortened dead time, and the link side
  pbmc_ctrl #(.DEAD_CYC(50), .SWRST_CYC(16)) dut_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hready),
    .hrdata_out(hrdata_out), .hreadyout_out(hready), .hresp_out(),
    .an_speed_in(an_speed_in), .an_duplex_in(an_duplex_in),
    .an_started_in(an_started_in), .tx_active_in(tx_active_in),
    .an_enable_out(), .an_restart_out(an_restart_out),
    .speed_100_out(spd), .full_duplex_out(dpx), .loopback_out(loopback_out),
    .power_down_out(power_down_out), .isolate_out(),
    .collision_out(collision_out), .rx_dead_out(rx_dead_out),
    .phy_reset_out(sw_rst));
  pbmc_link_model link_u (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .an_restart_in(an_restart_out), .start_dly_in(8'h28),
    .tx_en_in(tx_en), .an_started_out(an_started_in),
    .tx_active_out(tx_active_in));
  function [31:0] xs(input [31:0] s);
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
    end
  endfunction
  // readback: manual fields, negotiated ones with autoneg on
  function [15:0] ex(input [15:0] w);
    begin
      ex = w & 16'h7d80;
      if (w[12]) ex = {ex[15:14], an_speed_in, ex[12:9], an_duplex_in, ex[7:0]};
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // bounded wait at rising edges: val 1 for hready high, val 0 for sw_rst and an_restart_out both low
  task upto(input val, input integer lim);
    begin
      n = 0;
      @(posedge core_clk_in);
      while ((val ? hready : ~(sw_rst | an_restart_out)) !== 1'b1) begin
        n = n + 1;
        if (n > lim) begin
          fail_count = fail_count + 1;
          conclude;
        end
        @(posedge core_clk_in);
      end
    end
  endtask
  // one single word transfer: address phase, then data phase
  task bus(input wr, input [31:0] a, input [15:0] wd);
    begin
      repeat (2) @(posedge core_clk_in);
      hsel_in <= 1'b1;
      haddr_in <= a;
      hwrite_in <= wr;
      htrans_in <= 2'h2;
      upto(1'b1, 50);
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= {16'h0000, wd};
      upto(1'b1, 50);
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    bus(0, 0, 0);
    chk(hrdata_out, 16'h3100);
    for (i = 0; i < 16; i = i + 1) begin
      seed = xs(seed);
      v = seed[15:0] & (seed[20] ? 16'h79ff : 16'h69ff);
      tx_en <= seed[16];
      an_speed_in <= seed[17];
      an_duplex_in <= seed[18];
      bus(1, 0, v);
      bus(0, 0, 0);
      e = ex(v);
      chk(hrdata_out, e);
      chk({spd, dpx, loopback_out, power_down_out}, {e[13], e[8],
        v[14], v[11]});
    end
    tx_en <= 1'b1;
    bus(1, 0, 16'h2080);
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge core_clk_in);
      if (i > 0) chk(collision_out, t);
      t = tx_active_in;
    end
    bus(1, 0, 16'h6000);
    @(posedge core_clk_in);
    chk(rx_dead_out, 1'b1);
    bus(1, 0, 16'h1200);
    bus(1, 0, 16'h1000);
    bus(0, 0, 0);
    chk(hrdata_out, ex(16'h1200) | 16'h0200);
    upto(1'b0, 100);
    bus(0, 0, 0);
    chk(hrdata_out, ex(16'h1000));
    an_speed_in <= 1'b1;
    an_duplex_in <= 1'b1;
    bus(1, 0, 16'hc800);
    bus(0, 0, 0);
    chk(hrdata_out, 16'hb100);
    upto(1'b0, 100);
    bus(0, 0, 0);
    chk(hrdata_out, 16'h3100);
    bus(0, 32'h4, 0);
    chk(hrdata_out, 0);
    conclude;
  end
endmodule
